/* verilog/kpi_pkg.sv */
package kpi_pkg;

    // register byte addresses on the bus
    // five word registers need a fifth address bit to reach 0x10
    localparam logic [4:0] KPI_ADDR_STATUS_CONTROL = 5'h00;
    localparam logic [4:0] KPI_ADDR_PIN_ENABLE = 5'h04;
    localparam logic [4:0] KPI_ADDR_POLARITY = 5'h08;
    localparam logic [4:0] KPI_ADDR_IRQ_STATUS = 5'h0c;
    localparam logic [4:0] KPI_ADDR_IRQ_MASK = 5'h10;

    // status/control field positions
    localparam int KPI_BIT_DETECT_MODE = 0;
    localparam int KPI_BIT_IRQ_ENABLE = 1;
    localparam int KPI_BIT_ACKNOWLEDGE = 2;
    localparam int KPI_BIT_EVENT_FLAG = 3;

    // implemented key inputs: bits 5, 4, 2, 1, 0
    localparam logic [7:0] KPI_PIN_MASK = 8'h37;
    localparam logic [7:0] KPI_CTRL_WRITE_MASK = 8'h03;

    // read default byte and bus response codes
    localparam logic [7:0] KPI_RESET_BYTE = 8'h00;
    localparam logic [1:0] KPI_RESP_OKAY = 2'h0;
    localparam logic [1:0] KPI_RESP_SLVERR = 2'h2;

    // interrupt status bits
    localparam int KPI_IRQ_BIT_EVENT = 0;
    localparam logic [7:0] KPI_IRQ_IMPL = 8'h01;

    typedef struct packed {
        logic [7:0] prev;
        logic [7:0] armed;
        logic [7:0] level;
        logic [7:0] rise;
    } kpi_detect_type;

    typedef struct packed {
        logic awvalid;
        logic [4:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [4:0] araddr;
        logic rready;
    } kpi_bus_in_type;

endpackage

/* verilog/kpi_edge_detect.sv */
`timescale 1ns/10ps
module kpi_edge_detect
    import kpi_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] pin_async,
    input wire logic [7:0] pin_enable,
    input wire logic [7:0] polarity,
    output logic [7:0] asserted_level,
    output logic [7:0] edge_seen
);

    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] armed;
    } kpi_edge_state_type;

    kpi_edge_state_type state;
    kpi_edge_state_type next_state;
    logic [7:0] active;

    // normalise so that 1 means asserted for either polarity
    assign active = state.sync2 ~^ polarity;

    always_comb begin
        next_state = state;
        next_state.sync1 = pin_async;
        next_state.sync2 = state.sync1;
        // arm only after the pin was seen deasserted for one cycle
        next_state.armed = ~active & pin_enable & KPI_PIN_MASK;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            assign asserted_level[i] = active[i] & pin_enable[i]
                & KPI_PIN_MASK[i];
            assign edge_seen[i] = state.armed[i] & active[i]
                & pin_enable[i];
        end
    endgenerate

endmodule // kpi_edge_detect

/* verilog/kpi_keypad_wake_unit.sv */
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module kpi_keypad_wake_unit
    import kpi_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] key_input_pin,
    input wire logic stop_mode,
    output logic key_irq,
    output logic stop_wakeup,
    output logic irq,
    input wire logic awvalid,
    output logic awready,
    input wire logic [4:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [4:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);

    typedef struct packed {
        logic aw_held;
        logic [4:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic b_valid;
        logic [1:0] b_resp;
        logic r_valid;
        logic [31:0] r_data;
        logic [1:0] r_resp;
        logic [7:0] pin_enable;
        logic [7:0] polarity;
        logic detect_mode;
        logic irq_enable;
        logic event_flag;
        logic [7:0] irq_status;
        logic [7:0] irq_mask;
    } kpi_state_type;

    kpi_state_type state;
    kpi_state_type next_state;
    logic [7:0] asserted_level;
    logic [7:0] edge_seen;
    logic event_hit;
    logic any_asserted;
    logic do_write;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic read_ok;
    logic write_ok;

    kpi_edge_detect u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_async(key_input_pin),
        .pin_enable(state.pin_enable),
        .polarity(state.polarity),
        .asserted_level(asserted_level),
        .edge_seen(edge_seen)
    );

    // detection runs on every clock whatever the cpu mode; only the
    // stop path below is combinational because the clock may be gated
    assign any_asserted = |asserted_level;
    assign event_hit = (|edge_seen)
        | (state.detect_mode & any_asserted);

    // stop wake: raw pin compared against polarity, no clock needed;
    // this is a level, so a caller must gate it into its own wake logic
    assign stop_wakeup = stop_mode & state.irq_enable
        & |((key_input_pin ~^ state.polarity) & state.pin_enable
        & KPI_PIN_MASK);

    assign awready = !state.aw_held && !state.b_valid;
    assign wready = !state.w_held && !state.b_valid;
    assign arready = !state.r_valid;
    assign bvalid = state.b_valid;
    assign bresp = state.b_resp;
    assign rvalid = state.r_valid;
    assign rdata = state.r_data;
    assign rresp = state.r_resp;
    assign key_irq = state.event_flag & state.irq_enable;
    assign irq = |(state.irq_status & state.irq_mask);

    assign do_write = state.aw_held && state.w_held && !state.b_valid;
    assign wbyte = state.w_strb[0] ? state.w_data[7:0] : 8'h00;
    assign write_ok = (state.aw_addr == KPI_ADDR_STATUS_CONTROL)
        || (state.aw_addr == KPI_ADDR_PIN_ENABLE)
        || (state.aw_addr == KPI_ADDR_POLARITY)
        || (state.aw_addr == KPI_ADDR_IRQ_STATUS)
        || (state.aw_addr == KPI_ADDR_IRQ_MASK);

    always_comb begin
        rbyte = KPI_RESET_BYTE;
        read_ok = 1'b1;
        case (araddr)
            KPI_ADDR_STATUS_CONTROL: begin
                // acknowledge bit always reads zero
                rbyte[KPI_BIT_EVENT_FLAG] = state.event_flag;
                rbyte[KPI_BIT_ACKNOWLEDGE] = 1'b0;
                rbyte[KPI_BIT_IRQ_ENABLE] = state.irq_enable;
                rbyte[KPI_BIT_DETECT_MODE] = state.detect_mode;
            end
            KPI_ADDR_PIN_ENABLE: begin
                rbyte = state.pin_enable;
            end
            KPI_ADDR_POLARITY: begin
                rbyte = state.polarity;
            end
            KPI_ADDR_IRQ_STATUS: begin
                rbyte = state.irq_status;
            end
            KPI_ADDR_IRQ_MASK: begin
                rbyte = state.irq_mask;
            end
            default: begin
                read_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_state = state;
        if (awvalid && awready) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_state.w_held = 1'b1;
            next_state.w_data = wdata;
            next_state.w_strb = wstrb;
        end
        if (state.b_valid && bready) begin
            next_state.b_valid = 1'b0;
        end
        if (state.r_valid && rready) begin
            next_state.r_valid = 1'b0;
        end
        if (arvalid && arready) begin
            next_state.r_valid = 1'b1;
            next_state.r_data = {24'h000000, rbyte};
            next_state.r_resp = read_ok ? KPI_RESP_OKAY : KPI_RESP_SLVERR;
        end
        if (do_write) begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.b_valid = 1'b1;
            next_state.b_resp = write_ok ? KPI_RESP_OKAY : KPI_RESP_SLVERR;
            case (state.aw_addr)
                KPI_ADDR_STATUS_CONTROL: begin
                    if (state.w_strb[0]) begin
                        next_state.detect_mode =
                            wbyte[KPI_BIT_DETECT_MODE];
                        next_state.irq_enable = wbyte[KPI_BIT_IRQ_ENABLE];
                        // level mode holds the flag while any pin asserts
                        if (wbyte[KPI_BIT_ACKNOWLEDGE]
                            && !(wbyte[KPI_BIT_DETECT_MODE]
                            && state.detect_mode && any_asserted)) begin
                            next_state.event_flag = 1'b0;
                        end
                    end
                end
                KPI_ADDR_PIN_ENABLE: begin
                    if (state.w_strb[0]) begin
                        next_state.pin_enable = wbyte & KPI_PIN_MASK;
                    end
                end
                KPI_ADDR_POLARITY: begin
                    if (state.w_strb[0]) begin
                        next_state.polarity = wbyte & KPI_PIN_MASK;
                    end
                end
                KPI_ADDR_IRQ_STATUS: begin
                    next_state.irq_status = state.irq_status & ~wbyte;
                end
                KPI_ADDR_IRQ_MASK: begin
                    next_state.irq_mask = wbyte & KPI_IRQ_IMPL;
                end
                default: begin
                    next_state.b_resp = KPI_RESP_SLVERR;
                end
            endcase
        end
        // set wins over a same-cycle acknowledge or status clear
        if (event_hit) begin
            next_state.event_flag = 1'b1;
            next_state.irq_status[KPI_IRQ_BIT_EVENT] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule // kpi_keypad_wake_unit

/* dv/kpi_properties.sv */
`timescale 1ns/10ps
module kpi_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stop_mode,
    input wire logic key_irq,
    input wire logic stop_wakeup,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bresp_holds: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped early");
    a_rdata_holds: assert property (rvalid && !rready |=> rvalid)
        else $error("read data dropped early");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_write_answer: assert property
        (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");
    a_write_refused: assert property (bvalid |-> !awready && !wready)
        else $error("write taken during response");
    a_read_refused: assert property (rvalid |-> !arready)
        else $error("read taken during response");
    a_unused_zero: assert property (rvalid |-> rdata[31:6] == 26'h0)
        else $error("unused read bits set");
    a_wake_in_stop: assert property (stop_wakeup |-> stop_mode)
        else $error("wakeup outside stop");
    // the flag only drops through a register write, never by itself
    a_flag_by_write: assert property ($fell(key_irq) |->
        $past(wvalid && wready) || $past(wvalid && wready, 2))
        else $error("request dropped without write");
endmodule // kpi_properties
bind kpi_keypad_wake_unit kpi_properties u_props (.*);

/* dv/kpi_key_switches.sv */
`timescale 1ns/10ps
module kpi_key_switches (
    input wire logic aclk,
    input wire logic slow,
    input wire logic [7:0] press,
    output logic [7:0] key_input_pin
);
    logic [7:0] noise = 8'h00;
    // unbonded positions chatter so that any use of them shows up
    always @(posedge aclk) noise <= ~noise;
    always @(press, noise, slow)
        key_input_pin <= #(slow ? 37 : 3) (press & 8'h37) | (noise & 8'hc8);
endmodule // kpi_key_switches

/* dv/kpi_keypad_wake_unit_test.sv */
`timescale 1ns/10ps
module kpi_keypad_wake_unit_test
    import kpi_pkg::*;
;
    logic aclk, aresetn, stop_mode, slow, key_irq, stop_wakeup, irq;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [4:0] awaddr, araddr;
    logic [3:0] wstrb;
    logic [7:0] key_input_pin, press;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp;
    int mismatches = 0;
    int samples_checked = 0;
    int pins[5] = '{0, 1, 2, 4, 5};
    logic [4:0] ctl = KPI_ADDR_STATUS_CONTROL;
    logic [4:0] regs[5] = '{KPI_ADDR_IRQ_STATUS, KPI_ADDR_STATUS_CONTROL,
        KPI_ADDR_PIN_ENABLE, KPI_ADDR_POLARITY, KPI_ADDR_IRQ_MASK};
    logic [7:0] wmask[5] = '{8'h00, 8'h03, 8'h37, 8'h37, 8'h01};

    kpi_keypad_wake_unit DUT (.*);
    kpi_key_switches u_keys (.aclk(aclk), .slow(slow), .press(press),
        .key_input_pin(key_input_pin));

    initial begin
        aclk = 0;
        forever #25 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask

    function automatic logic [31:0] ctrl_exp(input logic f, ie, m);
        return {28'h0, f, 1'b0, ie, m};
    endfunction

    // readies are read at the falling edge, where they already hold what
    // the next rising edge samples; avoids racing the design's flops
    task automatic xfer(input logic w, input logic [4:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        logic hs, ta, tw;
        hs = 0;
        {awvalid, wvalid, bready} <= {3{w}};
        {arvalid, rready} <= {2{!w}};
        awaddr <= a;
        araddr <= a;
        wdata <= wd;
        repeat (40) if (!hs) begin
            @(negedge aclk);
            ta = w ? awready : arready;
            tw = wready;
            hs = w ? bvalid : rvalid;
            rd = rdata;
            @(posedge aclk);
            if (ta) {awvalid, arvalid} <= 2'h0;
            if (tw) wvalid <= 0;
        end
        {bready, rready} <= 2'h0;
        @(posedge aclk);
        chk(hs, 1);
    endtask

    task automatic trial(input int k);
        logic [7:0] b, pol, en, off;
        logic m, ie;
        b = 8'h01 << pins[$urandom_range(4)];
        pol = 8'($urandom) & 8'h37;
        en = b | (8'($urandom) & 8'h37);
        off = 8'h37 & ~en;
        ie = k[0];
        m = k[1];
        slow <= 1'($urandom);
        press <= ~pol;
        xfer(1, ctl, 0, d);
        xfer(1, KPI_ADDR_POLARITY, {24'h0, pol}, d);
        xfer(1, KPI_ADDR_PIN_ENABLE, {24'h0, en}, d);
        idle(4);
        xfer(1, ctl, ctrl_exp(0, 0, m) | 4, d);
        xfer(1, ctl, ctrl_exp(0, ie, m), d);
        xfer(1, KPI_ADDR_IRQ_STATUS, 1, d);
        press <= ~pol ^ off;
        idle(8);
        chk(key_irq, 0);
        chk(irq, 0);
        press <= ~pol ^ off ^ b;
        idle(8);
        chk(key_irq, ie);
        chk(irq, 1);
        xfer(0, ctl, 0, d);
        chk(d, ctrl_exp(1, ie, m));
        stop_mode <= 1;
        idle(1);
        chk(stop_wakeup, ie);
        stop_mode <= 0;
        xfer(1, ctl, ctrl_exp(0, ie, m) | 4, d);
        idle(8);
        chk(key_irq, ie & m);
        press <= ~pol;
        idle(6);
        xfer(1, ctl, ctrl_exp(0, ie, m) | 4, d);
        xfer(0, ctl, 0, d);
        chk(d, ctrl_exp(0, ie, m));
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {stop_mode, slow, awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        press = 8'hff;
        aresetn = 0;
        void'($urandom(32'h8274));
        idle(8);
        aresetn <= 1;
        idle(1);
        foreach (regs[i]) begin
            xfer(0, regs[i], 0, d);
            chk(d, 0);
            xfer(1, regs[i], '1, d);
            xfer(0, regs[i], 0, d);
            chk(d, {24'h0, wmask[i]});
        end
        for (int k = 0; k < 12; k++) trial(k);
        report_and_stop();
    end

    initial begin
        #250000;
        mismatches++;
        report_and_stop();
    end
endmodule // kpi_keypad_wake_unit_test
